// *** fsr_pkg.sv ***
/*
 * Constants, carrier types and timing-free limits for the fieldbus slave
 * register block. Assumes a byte-level serial receiver and transmitter
 * outside the block, which also detects the inter-frame silence.
 */
// Functional notes
// RULE1: Parity register value 0 means odd parity, 1 means even parity.
// RULE2: Parity value 2 is also legal and means no parity.
// RULE3: Illegal parity writes leave the setting and return an exception.
// RULE4: Writing 1 to statistics clear zeroes every statistics counter.
// RULE5: Parity, statistics and mode registers support functions 0x06, 0x10, 0x03.
// RULE6: Proportional control: mode 0 is 1-5 V input, mode 1 is 4-20 mA.
// RULE7: On/off control: mode 0 uses both digital inputs, mode 1 one input.
// RULE8: Reported analog value scaling follows the selected input mode.
// RULE9: Master sends single write as 8 bytes, CRC low byte first.
// RULE10: Accepted single write is answered with an exact 8-byte echo.
// RULE11: Position demand above 100 is refused with an exception frame.
// RULE12: Exception frame is address, function plus 0x80, code, CRC, 5 bytes.
// RULE13: Master sends holding read as 8 bytes, CRC low byte first.
// RULE14: One-register read answer is 7 bytes with byte count 0x02.
// RULE15: Position demand lives at register address 0x0001.
// RULE16: Actual position is read at register address 0x0009.
// RULE17: Control type reads 0 for on/off and 1 for proportional.
// RULE18: Analog value spans 0-200 in current mode, 0-50 in voltage mode. Code tops out at 199 and 49.
// RULE19: Slave address register accepts only 1 to 247.
// RULE20: Frames with bad CRC or foreign address are dropped silently.
// RULE21: Statistics clear writes other than 1 change no counter.
package fsr_pkg;
    // Register addresses
    localparam logic [15:0] REG_DEMAND = 16'h0001;
    localparam logic [15:0] REG_ACTUAL = 16'h0009;
    localparam logic [15:0] REG_AIN    = 16'h0018;
    localparam logic [15:0] REG_CTL    = 16'h0020;
    localparam logic [15:0] REG_SLAVE  = 16'h0026;
    localparam logic [15:0] REG_PARITY = 16'h0028;
    localparam logic [15:0] REG_STATS  = 16'h0029;
    localparam logic [15:0] REG_MODE   = 16'h002a;
    // Function codes and exception codes
    localparam logic [7:0]  FC_READ    = 8'h03;
    localparam logic [7:0]  FC_WR1     = 8'h06;
    localparam logic [7:0]  FC_WRN     = 8'h10;
    localparam logic [7:0]  FC_EXC     = 8'h80;
    localparam logic [7:0]  EXC_NONE   = 8'h00;
    localparam logic [7:0]  EXC_FUNC   = 8'h01;
    localparam logic [7:0]  EXC_ADDR   = 8'h02;
    localparam logic [7:0]  EXC_VALUE  = 8'h03;
    localparam logic [7:0]  EXC_FAIL   = 8'h04;
    // Value limits
    localparam logic [15:0] DEMAND_MAX = 16'h0064;
    localparam logic [15:0] PARITY_MAX = 16'h0002;
    localparam logic [15:0] MODE_MAX   = 16'h0001;
    localparam logic [15:0] SLAVE_MIN  = 16'h0001;
    localparam logic [15:0] SLAVE_MAX  = 16'h00f7;
    localparam logic [15:0] STATS_GO   = 16'h0001;
    // Parity codes
    localparam logic [1:0]  PAR_ODD    = 2'h0;
    localparam logic [1:0]  PAR_EVEN   = 2'h1;
    localparam logic [1:0]  PAR_NONE   = 2'h2;
    // Reset values
    localparam logic [15:0] DEMAND_RST = 16'h0000;
    localparam logic [15:0] PARITY_RST = 16'h0001;
    localparam logic [15:0] MODE_RST   = 16'h0000;
    localparam logic [15:0] STATS_RST  = 16'h0000;
    // Frame layout
    localparam logic [5:0]  LEN_FIXED  = 6'h08;
    localparam logic [5:0]  LEN_WRN    = 6'h09;
    localparam logic [5:0]  LEN_EXC    = 6'h05;
    localparam logic [5:0]  LEN_RDHDR  = 6'h05;
    localparam logic [5:0]  LEN_ECHO   = 6'h08;
    localparam logic [15:0] CRC_INIT   = 16'hffff;
    localparam logic [15:0] CRC_POLY   = 16'ha001;
    // Analog scaling spans, raw full scale is 2**10
    localparam logic [7:0]  AIN_I_SPAN = 8'hc8;
    localparam logic [7:0]  AIN_V_SPAN = 8'h32;
    localparam int          AIN_SHIFT  = 10;

    // Byte stream from the serial receiver
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       frame_end;
    } fsr_rx_t;

    // Settings that steer the actuator and serial link
    typedef struct packed {
        logic [1:0]  parity;
        logic        use_current;
        logic        single_din;
        logic [15:0] demand;
    } fsr_cfg_t;
endpackage : fsr_pkg

// *** fsr_crc.sv ***
/*
 * One-byte step of the 16-bit serial frame checksum, purely combinational.
 * Assumes the caller holds the running value and seeds it with CRC_INIT.
 */
`timescale 1ns/1ps
module fsr_crc
    import fsr_pkg::*;
(
    input  wire logic [15:0] crc_in,
    input  wire logic [7:0]  data,
    output logic      [15:0] crc_out
);
    // Fold the byte in, then shift out eight bits LSB first
    always_comb
    begin
        crc_out = crc_in ^ {8'h00, data};
        for (int i = 0; i < 8; i++)
        begin
            crc_out = crc_out[0] ? ((crc_out >> 1) ^ CRC_POLY) : (crc_out >> 1);
        end
    end
endmodule : fsr_crc

// *** fsr_top.sv ***
/*
 * Serial fieldbus slave register bank: frame receive, checks, register
 * writes and response generation. Assumes the receiver marks the end of
 * frame by a frame_end pulse in a cycle without a byte, and that the
 * transmitter takes one byte per tx_valid and tx_ready cycle.
 */
`timescale 1ns/1ps
module fsr_top
    import fsr_pkg::*;
#(
    parameter int         MAX_QTY  = 4,
    parameter logic [7:0] ADDR_RST = 8'h01
)(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire fsr_rx_t     rx,
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output logic      [7:0]  tx_data,
    input  wire logic [15:0] actual_position,
    input  wire logic        control_type,
    input  wire logic [9:0]  ain_raw,
    output fsr_cfg_t         cfg,
    output logic             stats_clear
);
    localparam int BUF_N = 9 + 2 * MAX_QTY;
    typedef enum logic [1:0] {ST_RX, ST_CHK, ST_WR, ST_TX} fsr_st_t;
    typedef struct packed {
        fsr_st_t               st;
        logic [BUF_N-1:0][7:0] fb;
        logic [5:0]            cnt;
        logic                  ovf;
        logic [15:0]           crc;
        logic [3:0]            widx;
        logic [7:0]            exc;
        logic [5:0]            tidx;
        logic [5:0]            tlen;
        logic [7:0]            tbyte;
        logic [15:0]           demand;
        logic [15:0]           parity;
        logic [15:0]           stats;
        logic [15:0]           mode;
        logic [7:0]            slave;
        logic                  clr;
        logic [7:0]            ain;
    } fsr_state_t;
    fsr_state_t  s;
    fsr_state_t  next_s;
    logic [15:0] crc_out;
    logic [7:0]  fc;
    logic [15:0] start;
    logic [15:0] qty;
    logic [15:0] nwords;
    logic [15:0] wr_addr;
    logic [15:0] wr_val;
    logic [7:0]  wr_code;
    logic [16:0] chk_rd;
    logic [16:0] tx_rd;
    logic [5:0]  k;
    logic        to_tx;
    logic        frame_ok;
    logic [17:0] ain_prod;

    // Running checksum over received or transmitted bytes
    fsr_crc u_crc (
        .crc_in  (s.crc),
        .data    ((s.st == ST_TX) ? s.tbyte : rx.data),
        .crc_out (crc_out)
    );

    // Legality of a register write; returns exception code or none
    function automatic logic [7:0] wr_check(input logic [15:0] a, input logic [15:0] v);
        if (a == REG_DEMAND)
            return (v > DEMAND_MAX) ? EXC_FAIL : EXC_NONE;         // see RULE11
        else if (a == REG_PARITY)
            return (v > PARITY_MAX) ? EXC_FAIL : EXC_NONE;         // see RULE3
        else if (a == REG_STATS)
            return EXC_NONE;
        else if (a == REG_MODE)
            return (v > MODE_MAX) ? EXC_FAIL : EXC_NONE;
        else if (a == REG_SLAVE)
            return (v < SLAVE_MIN || v > SLAVE_MAX) ? EXC_FAIL : EXC_NONE; // see RULE19
        else
            return EXC_ADDR;
    endfunction : wr_check

    // Read decode; bit 16 marks a mapped address
    function automatic logic [16:0] rd_map(input logic [15:0] a, input fsr_state_t q,
                                           input logic [15:0] act, input logic ctl);
        if (a == REG_DEMAND)
            return {1'b1, q.demand};                               // see RULE15
        else if (a == REG_ACTUAL)
            return {1'b1, act};                                    // see RULE16
        else if (a == REG_AIN)
            return {1'b1, 8'h00, q.ain};                           // see RULE18
        else if (a == REG_CTL)
            return {1'b1, 15'h0000, ctl};                          // see RULE17
        else if (a == REG_SLAVE)
            return {1'b1, 8'h00, q.slave};
        else if (a == REG_PARITY)
            return {1'b1, q.parity};                               // see RULE5
        else if (a == REG_STATS)
            return {1'b1, q.stats};
        else if (a == REG_MODE)
            return {1'b1, q.mode};
        else
            return {1'b0, 16'h0000};
    endfunction : rd_map

    // Request fields and the word under check or write
    always_comb
    begin
        fc      = s.fb[1];
        start   = {s.fb[2], s.fb[3]};
        qty     = {s.fb[4], s.fb[5]};
        nwords  = (fc == FC_WR1) ? 16'h0001 : qty;
        wr_addr = start + {12'h000, s.widx};
        wr_val  = (fc == FC_WR1) ? qty : {s.fb[7 + 2 * s.widx], s.fb[8 + 2 * s.widx]};
        wr_code = wr_check(wr_addr, wr_val);
        chk_rd  = rd_map(wr_addr, s, actual_position, control_type);
        k       = s.tidx + 6'h01;
        tx_rd   = rd_map(start + {11'h000, 5'((k - 6'h03) >> 1)}, s,
                         actual_position, control_type);
    end

    // Frame acceptance: own address, clean CRC, exact length for 0x03, 0x06 and 0x10, at least four bytes for other functions
    always_comb
    begin
        frame_ok = !s.ovf && (s.crc == 16'h0000) && (s.fb[0] == s.slave); // see RULE20
        if (fc == FC_READ || fc == FC_WR1)
            frame_ok = frame_ok && (s.cnt == LEN_FIXED);           // see RULE9, RULE13
        else if (fc == FC_WRN)
            frame_ok = frame_ok && (s.cnt == LEN_WRN + 6'(s.fb[6]));
        else
            frame_ok = frame_ok && (s.cnt >= LEN_EXC - 6'h01);
    end

    // Analog input scaled to the span of the selected mode
    always_comb
    begin
        if (s.mode[0])
            ain_prod = {8'h00, ain_raw} * {10'h000, AIN_I_SPAN};   // see RULE8
        else
            ain_prod = {8'h00, ain_raw} * {10'h000, AIN_V_SPAN};   // see RULE8
    end

    // Next-state logic for the whole slave
    always_comb
    begin
        next_s     = s;
        next_s.clr = 1'b0;
        next_s.ain = ain_prod[AIN_SHIFT +: 8];
        to_tx      = 1'b0;
        case (s.st)
            ST_RX:
            begin
                if (rx.valid)
                begin
                    if (s.cnt < 6'(BUF_N))
                        next_s.fb[s.cnt] = rx.data;
                    else
                        next_s.ovf = 1'b1;
                    if (s.cnt != 6'h3f)
                        next_s.cnt = s.cnt + 6'h01;
                    next_s.crc = crc_out;
                end
                else if (rx.frame_end)
                begin
                    next_s.cnt  = 6'h00;
                    next_s.ovf  = 1'b0;
                    next_s.crc  = CRC_INIT;
                    next_s.widx = 4'h0;
                    next_s.exc  = EXC_NONE;
                    if (frame_ok)
                    begin
                        if (fc != FC_READ && fc != FC_WR1 && fc != FC_WRN)
                        begin
                            next_s.exc = EXC_FUNC;
                            to_tx      = 1'b1;
                        end
                        else if (fc != FC_WR1 && (qty == 16'h0000 ||
                                 qty > 16'(MAX_QTY) ||
                                 (fc == FC_WRN && {8'h00, s.fb[6]} != {qty[14:0], 1'b0})))
                        begin
                            next_s.exc = EXC_VALUE;
                            to_tx      = 1'b1;
                        end
                        else
                            next_s.st = ST_CHK;
                    end
                end
            end
            ST_CHK:
            begin
                if (fc == FC_READ && !chk_rd[16])
                begin
                    next_s.exc = EXC_ADDR;
                    to_tx      = 1'b1;
                end
                else if (fc != FC_READ && wr_code != EXC_NONE)
                begin
                    next_s.exc = wr_code;                          // see RULE3, RULE11
                    to_tx      = 1'b1;
                end
                else if ({12'h000, s.widx} == nwords - 16'h0001)
                begin
                    next_s.widx = 4'h0;
                    if (fc == FC_READ)
                        to_tx = 1'b1;
                    else
                        next_s.st = ST_WR;
                end
                else
                    next_s.widx = s.widx + 4'h1;
            end
            ST_WR:
            begin
                if (wr_addr == REG_DEMAND)
                    next_s.demand = wr_val;                        // see RULE15
                else if (wr_addr == REG_PARITY)
                    next_s.parity = wr_val;                        // see RULE1, RULE2
                else if (wr_addr == REG_MODE)
                    next_s.mode = wr_val;
                else if (wr_addr == REG_SLAVE)
                    next_s.slave = wr_val[7:0];
                else if (wr_addr == REG_STATS)
                begin
                    next_s.stats = wr_val;
                    next_s.clr   = (wr_val == STATS_GO);           // see RULE4, RULE21
                end
                if ({12'h000, s.widx} == nwords - 16'h0001)
                    to_tx = 1'b1;
                else
                    next_s.widx = s.widx + 4'h1;
            end
            ST_TX:
            begin
                if (tx_ready)
                begin
                    if (s.tidx == s.tlen - 6'h01)
                    begin
                        next_s.st  = ST_RX;
                        next_s.crc = CRC_INIT;
                    end
                    else
                    begin
                        next_s.tidx = k;
                        if (s.tidx < s.tlen - 6'h02)
                            next_s.crc = crc_out;
                        // Byte that follows the one just taken
                        if (k == s.tlen - 6'h02)
                            next_s.tbyte = crc_out[7:0];           // see RULE10
                        else if (k == s.tlen - 6'h01)
                            next_s.tbyte = s.crc[15:8];
                        else if (s.exc != EXC_NONE)
                            next_s.tbyte = (k == 6'h01) ? (fc | FC_EXC) : s.exc; // see RULE12
                        else if (fc == FC_READ && k == 6'h01)
                            next_s.tbyte = fc;
                        else if (fc == FC_READ && k == 6'h02)
                            next_s.tbyte = {qty[6:0], 1'b0};       // see RULE14
                        else if (fc == FC_READ)
                            next_s.tbyte = k[0] ? tx_rd[15:8] : tx_rd[7:0]; // see RULE14
                        else
                            next_s.tbyte = s.fb[k];                // see RULE10
                    end
                end
            end
            default:
                next_s.st = ST_RX;
        endcase
        // Start of a response: address byte first, fresh checksum
        if (to_tx)
        begin
            next_s.st    = ST_TX;
            next_s.tidx  = 6'h00;
            next_s.tbyte = s.fb[0];
            next_s.crc   = CRC_INIT;
            if (next_s.exc != EXC_NONE)
                next_s.tlen = LEN_EXC;                             // see RULE12
            else if (fc == FC_READ)
                next_s.tlen = LEN_RDHDR + {qty[4:0], 1'b0};        // see RULE14
            else
                next_s.tlen = LEN_ECHO;                            // see RULE10
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s        <= '0;
            s.st     <= ST_RX;
            s.crc    <= CRC_INIT;
            s.demand <= DEMAND_RST;
            s.parity <= PARITY_RST;
            s.stats  <= STATS_RST;
            s.mode   <= MODE_RST;
            s.slave  <= ADDR_RST;
        end
        else
            s <= next_s;
    end

    // Outputs
    assign tx_valid        = (s.st == ST_TX);
    assign tx_data         = s.tbyte;
    assign stats_clear     = s.clr;
    assign cfg.parity      = s.parity[1:0];                        // see RULE1, RULE2
    assign cfg.use_current = control_type & s.mode[0];             // see RULE6
    assign cfg.single_din  = !control_type & s.mode[0];            // see RULE7
    assign cfg.demand      = s.demand;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_parity_legal;
        cfg.parity != 2'h3;
    endproperty
    a_parity_legal: assert property (p_parity_legal) else $error("parity code illegal"); // see RULE2

    property p_parity_guard;
        $changed(s.parity) |-> $past(s.st) == ST_WR && $past(wr_val) <= PARITY_MAX;
    endproperty
    a_parity_guard: assert property (p_parity_guard) else $error("bad parity stored"); // see RULE3

    property p_clear_cause;
        stats_clear |-> $past(s.st == ST_WR && wr_addr == REG_STATS && wr_val == STATS_GO);
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("clear without cause"); // see RULE4

    property p_clear_other;
        (s.st == ST_WR && wr_addr == REG_STATS && wr_val != STATS_GO) |=> !stats_clear;
    endproperty
    a_clear_other: assert property (p_clear_other) else $error("clear on other value"); // see RULE21

    property p_demand_range;
        $changed(cfg.demand) |-> $past(wr_val) <= DEMAND_MAX && $past(s.st) == ST_WR;
    endproperty
    a_demand_range: assert property (p_demand_range) else $error("demand over range"); // see RULE11

    property p_exc_len;
        (s.st == ST_TX && s.exc != EXC_NONE) |-> s.tlen == LEN_EXC;
    endproperty
    a_exc_len: assert property (p_exc_len) else $error("exception length wrong"); // see RULE12

    property p_read_len;
        (s.st == ST_TX && s.exc == EXC_NONE && fc == FC_READ && qty == 16'h0001)
            |-> s.tlen == 6'h07;
    endproperty
    a_read_len: assert property (p_read_len) else $error("read length wrong"); // see RULE14

    property p_echo;
        (tx_valid && s.exc == EXC_NONE && fc == FC_WR1 && s.tidx > 6'h00 && s.tidx < 6'h06)
            |-> tx_data == s.fb[s.tidx] && s.tlen == 6'h08;
    endproperty
    a_echo: assert property (p_echo) else $error("echo byte differs"); // see RULE10

    property p_slave_range;
        s.slave >= SLAVE_MIN[7:0] && s.slave <= SLAVE_MAX[7:0];
    endproperty
    a_slave_range: assert property (p_slave_range) else $error("slave address illegal"); // see RULE19

    property p_drop;
        (s.st == ST_RX && !rx.valid && rx.frame_end && s.fb[0] != s.slave)
            |=> (s.st == ST_RX) [*2];
    endproperty
    a_drop: assert property (p_drop) else $error("foreign frame answered"); // see RULE20
endmodule : fsr_top

// *** fsr_master.sv ***
/*
 * Serial master model facing the slave register block: builds request
 * frames with checksum, sends them a byte per pulse, collects the answer.
 * Assumes the bench calls xfer once the previous answer has ended.
 */
`timescale 1ns/1ps
module fsr_master
    import fsr_pkg::*;
(
    input  wire logic       clk,
    output fsr_rx_t         rx,
    output logic            tx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data
);
    logic [7:0] req [0:15];
    logic [7:0] rsp [0:15];
    int         req_n;
    int         rsp_n;

    // Idle link at time zero
    initial
    begin
        rx = '0;
        tx_ready = 1'b0;
    end

    // Checksum over the first n bytes, low byte goes first on the wire
    function automatic logic [15:0] crc16(input logic [7:0] b [0:15], input int n);
        logic [15:0] c;
        c = CRC_INIT;
        for (int i = 0; i < n; i++)
        begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        return c;
    endfunction : crc16

    // One request and its answer; slow stalls the answer every other cycle
    task automatic xfer(input logic [7:0] sa, fc, input logic [15:0] a, d,
                        input bit bad, slow);
        logic [15:0] c;
        {req[0], req[1], req[2], req[3]} = {sa, fc, a};
        if (fc == FC_WRN)
            {req[4], req[5], req[6], req[7], req[8]} = {16'h0001, 8'h02, d};
        else
            {req[4], req[5]} = d;
        req_n = (fc == FC_WRN) ? 9 : 6;
        c = crc16(req, req_n) ^ {15'h0000, bad};
        {req[req_n + 1], req[req_n]} = c;
        req_n += 2;
        for (int i = 0; i < req_n; i++)
        begin
            @(negedge clk);
            rx.valid = 1'b1;
            rx.data = req[i];
            @(negedge clk);
            rx.valid = 1'b0;
            rx.data = ~req[i]; // Released line shows no stale byte
        end
        @(negedge clk);
        rx.frame_end = 1'b1;
        @(negedge clk);
        rx.frame_end = 1'b0;
        rsp_n = 0;
        for (int t = 0; t < 60; t++)
        begin
            @(negedge clk);
            if (!tx_valid && rsp_n > 0)
                break;
            tx_ready = slow ? t[0] : 1'b1;
            if (tx_valid && tx_ready && rsp_n < 16)
            begin
                rsp[rsp_n] = tx_data;
                rsp_n++;
            end
        end
        tx_ready = 1'b0; // Early answers must wait until the collector runs
    endtask : xfer
endmodule : fsr_master

// *** tb_fieldbus_slave_register_map.sv ***
/*
 * Self-checking bench for the slave register block: frames go through the
 * master model, answers and settings are compared with expected values.
 * Assumes the design's default slave address of 1.
 */
`timescale 1ns/1ps
`define M fsr_master_inst
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module tb_fieldbus_slave_register_map
    import fsr_pkg::*;
;
    logic        clk;
    logic        arst_n;
    fsr_rx_t     rx;
    logic        tx_ready;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic [15:0] actual_position;
    logic        control_type;
    logic [9:0]  ain_raw;
    fsr_cfg_t    cfg;
    logic        stats_clear;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          pulses = 0;

    fsr_top #(.MAX_QTY(4), .ADDR_RST(8'h01)) fsr_top_inst (.clk(clk), .arst_n(arst_n),
        .rx(rx), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
        .actual_position(actual_position), .control_type(control_type),
        .ain_raw(ain_raw), .cfg(cfg), .stats_clear(stats_clear));
    fsr_master fsr_master_inst (.clk(clk), .rx(rx), .tx_ready(tx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data));

    // Clock, clear-pulse counter and hang limit
    initial clk = 1'b0;
    always #5 clk = ~clk;
    always @(negedge clk) if (stats_clear) pulses++;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 10000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // Answer must repeat the request byte for byte
    task automatic echo;
        `CHK(`M.rsp_n, `M.req_n)
        for (int i = 0; i < `M.req_n; i++) `CHK(`M.rsp[i], `M.req[i])
    endtask : echo

    // Five-byte refusal with its own checksum
    task automatic exc(input logic [7:0] fc, code);
        `CHK(`M.rsp_n, 5)
        `CHK({`M.rsp[0], `M.rsp[1], `M.rsp[2]}, {8'h01, fc | FC_EXC, code})
        `CHK({`M.rsp[4], `M.rsp[3]}, `M.crc16(`M.rsp, 3))
    endtask : exc

    // One-register read and its seven-byte answer
    task automatic rd(input logic [15:0] a, v);
        `M.xfer(8'h01, FC_READ, a, 16'h0001, 0, 1);
        `CHK(`M.rsp_n, 7)
        `CHK({`M.rsp[0], `M.rsp[1], `M.rsp[2], `M.rsp[3], `M.rsp[4]}, {8'h01, FC_READ, 8'h02, v})
        `CHK({`M.rsp[6], `M.rsp[5]}, `M.crc16(`M.rsp, 5))
    endtask : rd

    // Main sequence
    initial
    begin
        arst_n = 1'b0;
        actual_position = 16'h0042;
        control_type = 1'b1;
        ain_raw = 10'h3ff;
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        rd(REG_PARITY, 16'h0001);
        for (int v = 0; v < 4; v++)
        begin
            `M.xfer(8'h01, FC_WR1, REG_PARITY, 16'(v), 0, v[0]);
            if (v < 3)
                echo();
            else
                exc(FC_WR1, EXC_FAIL);
            `CHK(cfg.parity, v < 3 ? 2'(v) : PAR_NONE)
        end
        `M.xfer(8'h01, FC_WRN, REG_PARITY, 16'h0000, 0, 0);
        `CHK({`M.rsp_n, `M.rsp[1], `M.rsp[5]}, {32'h8, FC_WRN, 8'h01})
        rd(REG_PARITY, 16'h0000);
        `M.xfer(8'h01, FC_WR1, REG_DEMAND, 16'h0064, 0, 1);
        echo();
        `CHK({`M.rsp[7], `M.rsp[6]}, 16'he1d9)
        `CHK(cfg.demand, DEMAND_MAX)
        `M.xfer(8'h01, FC_WR1, REG_DEMAND, 16'h0065, 0, 0);
        exc(FC_WR1, EXC_FAIL);
        `CHK(cfg.demand, 16'h0064)
        rd(REG_DEMAND, 16'h0064);
        rd(REG_ACTUAL, 16'h0042);
        `M.xfer(8'h01, FC_WR1, REG_STATS, 16'h0002, 0, 0);
        `CHK(pulses, 0)
        `M.xfer(8'h01, FC_WRN, REG_STATS, 16'h0001, 0, 0);
        `CHK(pulses, 1)
        rd(REG_STATS, 16'h0001);
        for (int v = 0; v < 4; v++)
        begin
            control_type = v[1];
            `M.xfer(8'h01, FC_WR1, REG_MODE, 16'(v[0]), 0, 0);
            `CHK({cfg.use_current, cfg.single_din}, {v[1] & v[0], !v[1] & v[0]})
            rd(REG_AIN, v[0] ? 16'h00c7 : 16'h0031);
            rd(REG_CTL, 16'(v[1]));
        end
        `M.xfer(8'h01, FC_WR1, REG_MODE, 16'h0002, 0, 0);
        exc(FC_WR1, EXC_FAIL);
        `M.xfer(8'h01, FC_WR1, REG_SLAVE, 16'h00f8, 0, 0);
        exc(FC_WR1, EXC_FAIL);
        `M.xfer(8'h01, FC_WR1, REG_SLAVE, 16'h0000, 0, 0);
        exc(FC_WR1, EXC_FAIL);
        `M.xfer(8'h01, FC_READ, REG_DEMAND, 16'h0005, 0, 0);
        exc(FC_READ, EXC_VALUE);
        `M.xfer(8'h01, FC_READ, 16'h0002, 16'h0001, 0, 1);
        exc(FC_READ, EXC_ADDR);
        `M.xfer(8'h01, 8'h04, REG_DEMAND, 16'h0001, 0, 0);
        exc(8'h04, EXC_FUNC);
        `M.xfer(8'h01, FC_READ, REG_DEMAND, 16'h0001, 1, 0);
        `CHK(`M.rsp_n, 0)
        `M.xfer(8'h02, FC_READ, REG_DEMAND, 16'h0001, 0, 0);
        `CHK(`M.rsp_n, 0)
        `M.xfer(8'h01, FC_WR1, REG_SLAVE, 16'h0002, 0, 0);
        echo();
        `M.xfer(8'h02, FC_READ, REG_DEMAND, 16'h0001, 0, 0);
        `CHK(`M.rsp_n, 7)
        tally_and_finish();
    end
endmodule : tb_fieldbus_slave_register_map
